// >>> src/rcir_pkg.sv
// package: register map, field positions and states of the reset cause and id block
package rcir_pkg;
  // =========================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFF_ID = 12'h000;
  localparam logic [11:0] OFF_CAUSE = 12'h004;
  localparam logic [11:0] OFF_CTRL1 = 12'h008;
  localparam logic [11:0] OFF_CTRL2 = 12'h00C;
  localparam logic [11:0] OFF_WP = 12'h100;
  localparam logic [11:0] OFF_ISTAT = 12'h104;
  localparam logic [11:0] OFF_IMASK = 12'h108;
  // plain storage registers: perf, brownout, temp, por, ports a-e, alt, and one more at 0x014
  localparam int NUM_GEN = 11;
  localparam logic [11:0] OFF_GEN [NUM_GEN] = '{12'h010, 12'h018, 12'h01C, 12'h024,
    12'h030, 12'h034, 12'h038, 12'h03C, 12'h040, 12'h050, 12'h014};
  localparam logic [31:0] GEN_RST = 32'h0000_0000;
  // =========================================
  // reset cause flag positions
  localparam int B_POR = 0;
  localparam int B_PIN = 1;
  localparam int B_WDT = 2;
  localparam int B_LVR = 3;
  localparam int B_BOD = 4;
  localparam int B_SYS = 5;
  localparam int B_CPU = 7;
  localparam logic [7:0] CAUSE_MASK = 8'hBF;
  localparam logic [7:0] CAUSE_RST = 8'h01;
  // =========================================
  // control register 1 fields
  localparam int C1_CHIP = 0;
  localparam int C1_CPU = 1;
  localparam logic [31:0] CTRL1_MASK = 32'h0000_000F;
  localparam logic [31:0] CTRL1_PROT = 32'h0000_000F;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] CPU_PULSE_CYC = 2'h2;
  // =========================================
  // write protection unlock keys and states
  localparam logic [7:0] KEY1 = 8'h59;
  localparam logic [7:0] KEY2 = 8'h16;
  localparam logic [7:0] KEY3 = 8'h88;
  typedef enum logic [3:0] {
    WP_LOCKED = 4'b0001,
    WP_KEY1 = 4'b0010,
    WP_KEY2 = 4'b0100,
    WP_OPEN = 4'b1000
  } rcir_wp_t;
endpackage

// >>> src/rcir_top.sv
// module: reset cause flags, part id and system control registers on apb
`timescale 1ns/1ps
// =========================================
// Behaviour
// - a read-only 32-bit part id register sits at offset 0x00.
// - the reset cause register at 0x04 has upper 24 bits zero and a low byte showing past resets.
// - the cause flags survive every reset they report; only power-on clears the store.
// - writing 1 to control 1 bit 1 resets the core only and sets cause bit 7.
// - a core system reset request sets cause bit 5.
// - a brown-out reset sets cause bit 4.
// - a low-voltage reset sets cause bit 3.
// - writing 1 to a cause bit clears it.
// - control registers 1 and 2 sit at 0x08 and 0x0C, read/write, reset to zero.
// - the write protection register sits at 0x100 and resets to zero.
// - a watchdog reset sets cause bit 2, cleared by writing 1.
// - a low level on the reset pin sets cause bit 1, cleared by writing 1.
// - power-on or the chip reset bit 0 of control 1 sets cause bit 0, cleared by writing 1.
module rcir_top import rcir_pkg::*; #(
  parameter logic [31:0] PART_ID = 32'h0000_0A5C, // arbitrary value
  parameter int ADDR_W = 12 // apb address width
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // power-on reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic watchdog_reset, // async reset from watchdog
  input wire logic low_voltage_reset, // async reset from low-voltage unit
  input wire logic brownout_reset, // async reset from brown-out detector
  input wire logic core_system_reset_request, // async core reset request
  input wire logic pin_reset_n, // raw external reset pin
  output logic core_only_reset, // core and flash ctrl reset
  output logic chip_reset_req, // whole chip reset pulse
  output logic [31:0] periph_ctrl_2, // peripheral reset lines
  output logic protect_open, // protected bits writable
  output logic irq // level interrupt
);
  // =========================================
  // elaboration checks
  // the decode slices paddr[11:0], so narrower buses cannot be served
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 12 to 32");
  end

  // =========================================
  // source synchronisers
  // order matches cause bits 1..5: pin, watchdog, low-voltage, brownout, core request
  logic [4:0] src_raw;
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] seen_reg;
  logic [4:0] src_edge;
  assign src_raw = {core_system_reset_request, brownout_reset, low_voltage_reset, watchdog_reset, ~pin_reset_n};
  for (genvar s = 0; s < 5; s++) begin : g_sync
    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_reg[s] <= 1'b0;
        sync2_reg[s] <= 1'b0;
        seen_reg[s] <= 1'b0;
      end else begin
        sync1_reg[s] <= src_raw[s];
        sync2_reg[s] <= sync1_reg[s];
        seen_reg[s] <= sync2_reg[s];
      end
    end
    assign src_edge[s] = sync2_reg[s] & ~seen_reg[s];
  end

  // =========================================
  // bus decode
  logic [11:0] addr;
  logic wr;
  logic [NUM_GEN-1:0] gen_hit;
  logic [31:0] gen_reg [NUM_GEN];
  logic [31:0] gen_next [NUM_GEN];
  assign addr = paddr[11:0];
  // access phase edge: pready is high only there
  assign wr = psel & penable & pwrite & pready;
  for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
    assign gen_hit[g] = (addr == OFF_GEN[g]);
    // plain storage, no side effects
    always_comb begin
      gen_next[g] = gen_reg[g];
      if (wr && gen_hit[g]) begin
        gen_next[g] = pwdata;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gen_reg[g] <= GEN_RST;
      end else begin
        gen_reg[g] <= gen_next[g];
      end
    end
  end

  // =========================================
  // state registers
  logic [7:0] flags_reg, flags_next;
  logic [31:0] ctrl1_reg, ctrl1_next;
  logic [31:0] ctrl2_reg, ctrl2_next;
  logic [1:0] cpu_cnt_reg, cpu_cnt_next;
  rcir_wp_t wp_reg, wp_next;
  logic [7:0] istat_reg, istat_next;
  logic [7:0] imask_reg, imask_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next, irq_next;
  logic [7:0] set_vec, clr_vec;
  logic cpu_set, chip_set, hit_any, hi_zero;
  logic [31:0] gen_rd;

  // =========================================
  // next-state logic
  always_comb begin
    hi_zero = (ADDR_W <= 12) || (paddr >> 12) == '0;
    cpu_set = wr && hi_zero && addr == OFF_CTRL1 && wp_reg == WP_OPEN && pwdata[C1_CPU];
    chip_set = wr && hi_zero && addr == OFF_CTRL1 && wp_reg == WP_OPEN && pwdata[C1_CHIP];
    // set wins over clear in the same cycle
    set_vec = {cpu_set, 1'b0, src_edge, chip_set};
    clr_vec = (wr && hi_zero && addr == OFF_CAUSE) ? pwdata[7:0] : 8'h00;
    flags_next = ((flags_reg & ~clr_vec) | set_vec) & CAUSE_MASK;
    // interrupt status mirrors cause events but is cleared on its own
    istat_next = (istat_reg & ~((wr && hi_zero && addr == OFF_ISTAT) ? pwdata[7:0] : 8'h00)) | set_vec;
    imask_next = (wr && hi_zero && addr == OFF_IMASK) ? (pwdata[7:0] & CAUSE_MASK) : imask_reg;
    irq_next = |(istat_reg & imask_reg);
    // control 1: protected bits need the unlock sequence; one-shot bits self-clear
    ctrl1_next = ctrl1_reg;
    cpu_cnt_next = cpu_cnt_reg;
    if (wr && hi_zero && addr == OFF_CTRL1) begin
      ctrl1_next = ((pwdata & ~CTRL1_PROT) | ((wp_reg == WP_OPEN) ? (pwdata & CTRL1_PROT) : (ctrl1_reg & CTRL1_PROT)))
        & CTRL1_MASK;
    end
    if (chip_set == 1'b0 && ctrl1_reg[C1_CHIP]) begin
      ctrl1_next[C1_CHIP] = 1'b0;
    end
    // core reset stands for exactly two cycles
    if (cpu_set) begin
      cpu_cnt_next = CPU_PULSE_CYC;
    end else if (cpu_cnt_reg != 2'h0) begin
      cpu_cnt_next = cpu_cnt_reg - 2'h1;
      if (cpu_cnt_reg == 2'h1) begin
        ctrl1_next[C1_CPU] = 1'b0;
      end
    end
    ctrl2_next = (wr && hi_zero && addr == OFF_CTRL2) ? pwdata : ctrl2_reg;
    // unlock: three keys in a row; any write to the lock register while open locks again
    wp_next = wp_reg;
    if (wr && hi_zero && addr == OFF_WP) begin
      case (wp_reg)
        WP_LOCKED: wp_next = (pwdata[7:0] == KEY1) ? WP_KEY1 : WP_LOCKED;
        WP_KEY1: wp_next = (pwdata[7:0] == KEY2) ? WP_KEY2 : WP_LOCKED;
        WP_KEY2: wp_next = (pwdata[7:0] == KEY3) ? WP_OPEN : WP_LOCKED;
        WP_OPEN: wp_next = WP_LOCKED;
        default: wp_next = WP_LOCKED;
      endcase
    end
  end

  // =========================================
  // read mux, answered in the setup cycle so pready is high in the access cycle
  always_comb begin
    gen_rd = 32'h0000_0000;
    for (int i = 0; i < NUM_GEN; i++) begin
      if (gen_hit[i]) begin
        gen_rd = gen_reg[i];
      end
    end
    hit_any = hi_zero && paddr[1:0] == 2'h0 && ((|gen_hit) || addr == OFF_ID || addr == OFF_CAUSE
      || addr == OFF_CTRL1 || addr == OFF_CTRL2 || addr == OFF_WP || addr == OFF_ISTAT || addr == OFF_IMASK);
    prdata_next = 32'h0000_0000;
    if (psel && !penable && !pwrite && hit_any) begin
      case (addr)
        OFF_ID: prdata_next = PART_ID;
        OFF_CAUSE: prdata_next = {24'h000000, flags_reg};
        OFF_CTRL1: prdata_next = ctrl1_reg;
        OFF_CTRL2: prdata_next = ctrl2_reg;
        OFF_WP: prdata_next = {31'h0000_0000, wp_reg == WP_OPEN};
        OFF_ISTAT: prdata_next = {24'h000000, istat_reg};
        OFF_IMASK: prdata_next = {24'h000000, imask_reg};
        default: prdata_next = gen_rd;
      endcase
    end
    pready_next = psel & ~penable;
    pslverr_next = psel & ~penable & ~hit_any;
  end

  // =========================================
  // registers; power-on reset is the only reset that clears the cause store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= CAUSE_RST;
      ctrl1_reg <= CTRL_RST;
      ctrl2_reg <= CTRL_RST;
      cpu_cnt_reg <= 2'h0;
      wp_reg <= WP_LOCKED;
      istat_reg <= 8'h00;
      imask_reg <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      cpu_cnt_reg <= cpu_cnt_next;
      wp_reg <= wp_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      irq <= irq_next;
    end
  end

  // outputs straight from flops
  assign core_only_reset = ctrl1_reg[C1_CPU];
  assign chip_reset_req = ctrl1_reg[C1_CHIP];
  assign periph_ctrl_2 = ctrl2_reg;
  assign protect_open = (wp_reg == WP_OPEN);

  // =========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd(logic [11:0] a);
    psel && !penable && !pwrite && hi_zero && addr == a;
  endsequence

  chk_id_read: assert property (s_rd(OFF_ID) |=> prdata == PART_ID && pready)
    else $error("part id read wrong");
  chk_cause_read: assert property (s_rd(OFF_CAUSE) |=> prdata[7:0] == $past(flags_reg))
    else $error("cause read wrong");
  chk_reserved_zero: assert property (s_rd(OFF_CAUSE) |=> prdata[31:8] == 24'h0 && !prdata[6])
    else $error("cause reserved bits not zero");
  chk_cpu_pulse: assert property (cpu_set |=> core_only_reset [*2] ##1 !core_only_reset)
    else $error("core reset pulse wrong");
  chk_cpu_flag: assert property (cpu_set |=> flags_reg[B_CPU])
    else $error("core reset flag not set");
  chk_sys_flag: assert property ($rose(sync2_reg[4]) |-> ##[0:1] flags_reg[B_SYS])
    else $error("core request flag not set");
  chk_bod_flag: assert property ($rose(sync2_reg[3]) |-> ##[0:1] flags_reg[B_BOD])
    else $error("brownout flag not set");
  chk_lvr_flag: assert property ($rose(sync2_reg[2]) |-> ##[0:1] flags_reg[B_LVR])
    else $error("low voltage flag not set");
  chk_wdt_flag: assert property ($rose(sync2_reg[1]) |-> ##[0:1] flags_reg[B_WDT])
    else $error("watchdog flag not set");
  chk_pin_flag: assert property ($rose(sync2_reg[0]) |-> ##[0:1] flags_reg[B_PIN])
    else $error("pin flag not set");
  chk_chip_flag: assert property (chip_set |=> flags_reg[B_POR] && chip_reset_req ##1 !chip_reset_req)
    else $error("chip reset flag or pulse wrong");
  chk_w1c_clear: assert property (wr && addr == OFF_CAUSE && hi_zero && set_vec == 8'h00
    |=> (flags_reg & $past(pwdata[7:0])) == 8'h00)
    else $error("cause flag not cleared");
  chk_flags_keep: assert property (clr_vec == 8'h00 && set_vec == 8'h00 |=> $stable(flags_reg))
    else $error("cause flags changed without cause");
  chk_ctrl2_write: assert property (wr && hi_zero && addr == OFF_CTRL2 |=> periph_ctrl_2 == $past(pwdata))
    else $error("control 2 write lost");
  chk_unlock_seq: assert property (protect_open |-> $past(wp_reg) inside {WP_KEY2, WP_OPEN})
    else $error("unlock without key sequence");

  // =========================================
  // bus handshake and register store checks

  // every setup cycle is answered in the very next cycle
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");

  // no ready without a selected transfer
  chk_ready_idle: assert property (!psel |=> !pready)
    else $error("ready while idle");

  // unmapped address answers with error and zero data
  chk_err_unmapped: assert property (psel && !penable && !hit_any |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // mapped address never flags an error
  chk_err_mapped: assert property (psel && !penable && hit_any |=> !pslverr)
    else $error("error on mapped access");

  // read data is zero outside the access cycle of a read
  chk_rdata_idle: assert property (!(psel && !penable && !pwrite) |=> prdata == 32'h0000_0000)
    else $error("read data outside read");

  // an error only comes together with ready
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");

  // control 1 upper bits are not implemented
  chk_ctrl1_reserved: assert property (ctrl1_reg[31:4] == 28'h0000000)
    else $error("control 1 reserved bits set");

  // locked writes leave control 1 alone when no one-shot is running
  chk_ctrl1_locked: assert property (wr && hi_zero && addr == OFF_CTRL1 && wp_reg != WP_OPEN
    && !ctrl1_reg[C1_CPU] && !ctrl1_reg[C1_CHIP] |=> $stable(ctrl1_reg))
    else $error("locked control 1 changed");

  // control 2 only changes on its own write
  chk_ctrl2_keep: assert property (!(wr && hi_zero && addr == OFF_CTRL2) |=> $stable(ctrl2_reg))
    else $error("control 2 changed without write");

  // =========================================
  // write protection checks

  // a wrong first key keeps the lock shut
  chk_wp_wrong_key: assert property (wr && hi_zero && addr == OFF_WP && wp_reg == WP_LOCKED
    && pwdata[7:0] != KEY1 |=> wp_reg == WP_LOCKED)
    else $error("wrong key advanced unlock");

  // the right first key moves one step on
  chk_wp_first_key: assert property (wr && hi_zero && addr == OFF_WP && wp_reg == WP_LOCKED
    && pwdata[7:0] == KEY1 |=> wp_reg == WP_KEY1)
    else $error("first key not taken");

  // the third key opens the protected bits
  chk_wp_last_key: assert property (wr && hi_zero && addr == OFF_WP && wp_reg == WP_KEY2
    && pwdata[7:0] == KEY3 |=> protect_open)
    else $error("third key did not open");

  // any write to the lock register while open locks again
  chk_wp_relock: assert property (wr && hi_zero && addr == OFF_WP && wp_reg == WP_OPEN |=> !protect_open)
    else $error("open state not relocked");

  // the lock state only moves on its own register
  chk_wp_hold: assert property (!(wr && hi_zero && addr == OFF_WP) |=> $stable(wp_reg))
    else $error("lock state moved without write");

  // lock state stays one-hot
  chk_wp_onehot: assert property ($onehot(wp_reg))
    else $error("lock state not one-hot");

  // =========================================
  // cause flag, interrupt and one-shot checks

  // every set request lands in the cause store
  chk_flags_set: assert property (set_vec != 8'h00 |=> (flags_reg & $past(set_vec)) == $past(set_vec))
    else $error("cause flag set lost");

  // reserved cause bit 6 never sets
  chk_bit6_zero: assert property (!flags_reg[6])
    else $error("reserved cause bit set");

  // every set request lands in the interrupt status too
  chk_istat_set: assert property (set_vec != 8'h00 |=> (istat_reg & $past(set_vec)) == $past(set_vec))
    else $error("interrupt status set lost");

  // writing ones clears interrupt status
  chk_istat_clear: assert property (wr && hi_zero && addr == OFF_ISTAT && set_vec == 8'h00
    |=> (istat_reg & $past(pwdata[7:0])) == 8'h00)
    else $error("interrupt status not cleared");

  // mask takes the written value with bit 6 dropped
  chk_imask_write: assert property (wr && hi_zero && addr == OFF_IMASK
    |=> imask_reg == ($past(pwdata[7:0]) & CAUSE_MASK))
    else $error("mask write wrong");

  // reserved mask bit stays zero
  chk_imask_bit6: assert property (!imask_reg[6])
    else $error("reserved mask bit set");

  // an unmasked status bit raises the interrupt a cycle later
  chk_irq_high: assert property (|(istat_reg & imask_reg) |=> irq)
    else $error("interrupt not raised");

  // no unmasked status bit, no interrupt
  chk_irq_low: assert property (!(|(istat_reg & imask_reg)) |=> !irq)
    else $error("interrupt without cause");

  // the one-shot counter never runs past its load value
  chk_cnt_range: assert property (cpu_cnt_reg <= CPU_PULSE_CYC)
    else $error("core reset counter out of range");

  // counter steps down by one
  chk_cnt_step: assert property (cpu_cnt_reg == 2'h2 && !cpu_set |=> cpu_cnt_reg == 2'h1)
    else $error("core reset counter skipped");

  // an idle counter means the core is out of reset
  chk_cnt_idle: assert property (cpu_cnt_reg == 2'h0 |-> !core_only_reset)
    else $error("core reset without counter");

  // chip reset request is a single-cycle pulse
  chk_chip_once: assert property (chip_reset_req |=> !chip_reset_req)
    else $error("chip reset pulse too long");
endmodule // rcir_top

// >>> dv/test_reset_cause_and_id_regs.sv
// testbench: apb register checks, reset cause events, interrupt and core reset pulses
`timescale 1ns/1ps
module test_reset_cause_and_id_regs;
  import rcir_pkg::*;
  // =========================================
  // signals and counters
  localparam logic [31:0] ID_VAL = 32'h0000_3C71; // arbitrary value
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, periph_ctrl_2, r;
  logic pready, pslverr, core_only_reset, chip_reset_req, protect_open, irq, e;
  logic [4:0] ev = 5'h00; // watchdog, low voltage, brownout, core request, pin
  int n_fail = 0, total_checks = 0, n_core = 0, n_chip = 0;
  rcir_top #(.PART_ID(ID_VAL), .ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_reset(ev[0]), .low_voltage_reset(ev[1]),
    .brownout_reset(ev[2]), .core_system_reset_request(ev[3]), .pin_reset_n(~ev[4]),
    .core_only_reset(core_only_reset), .chip_reset_req(chip_reset_req),
    .periph_ctrl_2(periph_ctrl_2), .protect_open(protect_open), .irq(irq));
  // 50 MHz clock
  always #10 pclk = ~pclk;
  // pulse widths counted edge by edge so no cycle of the pulse is missed
  always @(posedge pclk) begin
    n_core += (core_only_reset === 1'b1);
    n_chip += (chip_reset_req === 1'b1);
  end
  // =========================================
  // helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge, leaves one idle edge behind it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp, m);
  endtask
  // event input held high for a few cycles, then the sync and set latency is let pass
  task automatic fire(input int k);
    ev[k] <= 1'b1;
    repeat (4) @(posedge pclk);
    ev[k] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic unlock();
    apb(1'b1, OFF_WP, 32'h0000_0059);
    apb(1'b1, OFF_WP, 32'h0000_0016);
    apb(1'b1, OFF_WP, 32'h0000_0088);
  endtask
  // =========================================
  // scenarios
  task automatic t_reset_map();
    rd(OFF_ID, ID_VAL, "id");
    apb(1'b1, OFF_ID, 32'hFFFF_FFFF);
    rd(OFF_ID, ID_VAL, "id read only");
    rd(OFF_CAUSE, 32'h0000_0001, "cause after power-on");
    rd(OFF_CTRL1, 32'h0000_0000, "ctrl1 reset");
    rd(OFF_CTRL2, 32'h0000_0000, "ctrl2 reset");
    rd(OFF_WP, 32'h0000_0000, "protect reset");
    apb(1'b1, OFF_CTRL2, 32'hA5C3_0F12);
    rd(OFF_CTRL2, 32'hA5C3_0F12, "ctrl2 rw");
    chk(periph_ctrl_2, 32'hA5C3_0F12, "ctrl2 port");
    rd(12'h0FC, 32'h0000_0000, "unmapped data");
    chk(e, 1'b1, "unmapped error");
  endtask
  task automatic t_events();
    int bitpos [5] = '{B_WDT, B_LVR, B_BOD, B_SYS, B_PIN};
    logic [31:0] exp;
    exp = 32'h0000_0001;
    for (int k = 0; k < 5; k++) begin
      fire(k);
      exp[bitpos[k]] = 1'b1;
      rd(OFF_CAUSE, exp, "cause accumulates");
    end
    apb(1'b1, OFF_CAUSE, 32'h0000_0000);
    rd(OFF_CAUSE, exp, "write zero keeps");
    apb(1'b1, OFF_CAUSE, 32'hFFFF_FF44);
    rd(OFF_CAUSE, 32'h0000_003B, "w1c and reserved");
    apb(1'b1, OFF_CAUSE, 32'h0000_00FF);
    rd(OFF_CAUSE, 32'h0000_0000, "all cleared");
  endtask
  task automatic t_irq();
    apb(1'b1, OFF_ISTAT, 32'h0000_00FF);
    apb(1'b1, OFF_IMASK, 32'h0000_0004);
    chk(irq, 1'b0, "irq idle");
    fire(0);
    rd(OFF_ISTAT, 32'h0000_0004, "istat set");
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, OFF_ISTAT, 32'h0000_0004);
    @(posedge pclk);
    chk(irq, 1'b0, "irq cleared");
    fire(1);
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, OFF_ISTAT, 32'h0000_00FF);
    apb(1'b1, OFF_CAUSE, 32'h0000_00FF);
  endtask
  task automatic t_core();
    apb(1'b1, OFF_CTRL1, 32'h0000_0003);
    rd(OFF_CTRL1, 32'h0000_0000, "locked ctrl1");
    rd(OFF_CAUSE, 32'h0000_0000, "locked no flag");
    unlock();
    chk(protect_open, 1'b1, "unlocked");
    n_core = 0;
    apb(1'b1, OFF_CTRL1, 32'h0000_0002);
    repeat (5) @(posedge pclk);
    chk(n_core, 2, "core reset width");
    rd(OFF_CTRL1, 32'h0000_0000, "core bit returns");
    rd(OFF_CAUSE, 32'h0000_0080, "core flag");
    // still open: a write to the lock register shuts it before the next key run
    apb(1'b1, OFF_WP, 32'h0000_0000);
    chk(protect_open, 1'b0, "relocked");
    unlock();
    chk(protect_open, 1'b1, "unlocked again");
    n_chip = 0;
    apb(1'b1, OFF_CTRL1, 32'h0000_0001);
    repeat (5) @(posedge pclk);
    chk(n_chip, 1, "chip pulse width");
    rd(OFF_CAUSE, 32'h0000_0081, "chip flag");
  endtask
  // =========================================
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_map();
    t_events();
    t_irq();
    t_core();
    summarize();
  end
endmodule // test_reset_cause_and_id_regs
